/* File: src/periodic_wakeup_pkg.sv */
// Constants, register map and divider table for the periodic wakeup counter
// Overview of operation
// R01: The match flag sets when the counter reaches the modulo value, clears on a write of one, ignores zero, clears on reset.
// R02: Source select 00 picks the low-power oscillator, 01 the external reference, 1x the internal reference.
// R03: Writing a different source select value clears prescaler and counter; reset clears the field.
// R04: The interrupt request is high while the match flag and the interrupt enable are both set; reset clears the enable.
// R05: Writing a different prescale select value clears prescaler and counter; reset clears the field.
// R06: With source bit 0 low, selection 0 is off, 1-7 divide by 8 to 1024, 8-15 by 1,2,4,10,16,100,500,1000.
// R07: With source bit 0 high, selection 0 is off, 1-7 divide by 2^10 to 2^16, 8-15 by 1000 up to 200000.
// R08: The count register is a read-only view of the 8-bit counter, writes are ignored, reset clears it.
// R09: On a compare match the counter returns to zero and the match flag sets.
// R10: With a modulo of zero the flag sets on every prescaler output pulse.
// R11: Any write to the modulo register clears prescaler and counter; reset loads the modulo with zero.
// R12: After reset counting is stopped until a nonzero prescale selection is written.
// R13: After reset the low-power oscillator is the selected source.
// R14: The main counter is an 8-bit up-counter advanced by the prescaler and compared with the modulo register.
// R15: Control writes reach the counting logic safely and count reads are coherent.
// R16: Software enables a reference clock before selecting it, or the counter does not advance.
package periodic_wakeup_pkg;

    localparam int DATA_W = 8;
    localparam int DIV_W = 18;
    localparam int NUM_SRC = 3;

    // Register byte offsets
    localparam logic [7:0] STATUS_CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] COUNT_VALUE_OFFSET = 8'h04;
    localparam logic [7:0] MODULO_VALUE_OFFSET = 8'h08;

    // Status/control field positions
    localparam int FLAG_BIT = 7;
    localparam int SRC_HI = 6;
    localparam int SRC_LO = 5;
    localparam int IE_BIT = 4;
    localparam int PS_HI = 3;
    localparam int PS_LO = 0;

    // Reset values
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [3:0] PS_RESET = 4'h0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] MODULO_RESET = 8'h00;
    localparam logic [DIV_W-1:0] PRESCALE_RESET = 18'h0_0000;

    // Source indices into the synchronised clock vector
    localparam int SRC_LPO = 0;
    localparam int SRC_EXT = 1;
    localparam int SRC_INT = 2;

    // Divide value for a source bit and prescale selection; zero means off
    function automatic logic [DIV_W-1:0] divisor(input logic src_lo, input logic [3:0] ps);
        logic [DIV_W-1:0] d;
        d = 18'h0_0000;
        unique case ({src_lo, ps}) // R06 R07
            5'h00: d = 18'h0_0000;
            5'h01: d = 18'h0_0008;
            5'h02: d = 18'h0_0020;
            5'h03: d = 18'h0_0040;
            5'h04: d = 18'h0_0080;
            5'h05: d = 18'h0_0100;
            5'h06: d = 18'h0_0200;
            5'h07: d = 18'h0_0400;
            5'h08: d = 18'h0_0001;
            5'h09: d = 18'h0_0002;
            5'h0A: d = 18'h0_0004;
            5'h0B: d = 18'h0_000A;
            5'h0C: d = 18'h0_0010;
            5'h0D: d = 18'h0_0064;
            5'h0E: d = 18'h0_01F4;
            5'h0F: d = 18'h0_03E8;
            5'h10: d = 18'h0_0000;
            5'h11: d = 18'h0_0400;
            5'h12: d = 18'h0_0800;
            5'h13: d = 18'h0_1000;
            5'h14: d = 18'h0_2000;
            5'h15: d = 18'h0_4000;
            5'h16: d = 18'h0_8000;
            5'h17: d = 18'h1_0000;
            5'h18: d = 18'h0_03E8;
            5'h19: d = 18'h0_07D0;
            5'h1A: d = 18'h0_1388;
            5'h1B: d = 18'h0_2710;
            5'h1C: d = 18'h0_4E20;
            5'h1D: d = 18'h0_C350;
            5'h1E: d = 18'h1_86A0;
            5'h1F: d = 18'h3_0D40;
        endcase
        return d;
    endfunction

endpackage

/* File: src/source_edge_detect.sv */
// Two-flop synchronisers and rising-edge detectors for the source clock pins
`timescale 1ns/10ps
module source_edge_detect #(
    parameter int N = 3
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] rise
);
    logic [N-1:0] meta_reg;
    logic [N-1:0] sync_reg;
    logic [N-1:0] last_reg;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_src
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                    last_reg[i] <= 1'b0;
                end
                else if (ce)
                begin
                    meta_reg[i] <= pin_in[i];
                    sync_reg[i] <= meta_reg[i];
                    last_reg[i] <= sync_reg[i];
                end
            end
            assign rise[i] = sync_reg[i] & ~last_reg[i];
        end
    endgenerate
endmodule

/* File: src/prescale_divider.sv */
// Prescaler that divides source edges by a selectable value
`timescale 1ns/10ps
module prescale_divider #(
    parameter int DIV_W = 18
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic clear,
    input wire logic edge_in,
    input wire logic [DIV_W-1:0] divide_by,
    output logic tick
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (clear)
        begin
            cnt_next = '0;
        end
        else if ((divide_by != '0) && edge_in) // R12
        begin
            if (cnt_reg >= divide_by - DIV_W'(1))
            begin
                cnt_next = '0;
                tick_next = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cnt_reg <= periodic_wakeup_pkg::PRESCALE_RESET;
            tick_reg <= 1'b0;
        end
        else if (ce)
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

/* File: src/periodic_wakeup_counter.sv */
// Periodic wakeup counter with APB register access
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module periodic_wakeup_counter #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_power_osc_clock,
    input wire logic external_reference_clock,
    input wire logic internal_reference_clock,
    output logic periodic_irq
);
    localparam int DW = periodic_wakeup_pkg::DATA_W;
    localparam int NS = periodic_wakeup_pkg::NUM_SRC;
    localparam int DV = periodic_wakeup_pkg::DIV_W;

    // Control and status state
    logic periodic_match_flag_reg;
    logic periodic_match_flag_next;
    logic periodic_irq_enable_reg;
    logic periodic_irq_enable_next;
    logic [1:0] source_select_reg;
    logic [1:0] source_select_next;
    logic [3:0] prescale_select_reg;
    logic [3:0] prescale_select_next;
    logic [DW-1:0] periodic_modulo_value_reg;
    logic [DW-1:0] periodic_modulo_value_next;
    logic [DW-1:0] periodic_count_value_reg;
    logic [DW-1:0] periodic_count_value_next;
    logic irq_reg;
    logic irq_next;

    // Bus answer state
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Decode
    logic access;
    logic wr_commit;
    logic wr_lane;
    logic sel_ctrl;
    logic sel_count;
    logic sel_mod;
    logic mapped;
    logic [DW-1:0] wbyte;
    logic counter_clear;
    logic match;

    // Clock source path
    logic [NS-1:0] src_pins;
    logic [NS-1:0] src_rise;
    logic chosen_rise;
    logic prescale_tick;
    logic [DV-1:0] divide_by;
    logic [DW-1:0] ctrl_view;

    assign src_pins[periodic_wakeup_pkg::SRC_LPO] = low_power_osc_clock;
    assign src_pins[periodic_wakeup_pkg::SRC_EXT] = external_reference_clock;
    assign src_pins[periodic_wakeup_pkg::SRC_INT] = internal_reference_clock;

    // Pins are synchronised before use
    source_edge_detect #(
        .N(NS)
    ) u_edges (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .pin_in(src_pins),
        .rise(src_rise)
    );

    // Source multiplexer
    always_comb
    begin
        chosen_rise = src_rise[periodic_wakeup_pkg::SRC_LPO]; // R02 R13
        if (source_select_reg[1])
        begin
            chosen_rise = src_rise[periodic_wakeup_pkg::SRC_INT]; // R02 R16
        end
        else if (source_select_reg[0])
        begin
            chosen_rise = src_rise[periodic_wakeup_pkg::SRC_EXT]; // R02 R16
        end
    end

    assign divide_by = periodic_wakeup_pkg::divisor(source_select_reg[0], prescale_select_reg);

    prescale_divider #(
        .DIV_W(DV)
    ) u_prescale (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .clear(counter_clear),
        .edge_in(chosen_rise),
        .divide_by(divide_by),
        .tick(prescale_tick)
    );

    // APB decode; a write lands on the edge where pready is sampled high
    assign access = psel & penable;
    assign wr_commit = access & pready_reg & pwrite & ~pslverr_reg;
    assign wr_lane = wr_commit & pstrb[0];
    assign wbyte = pwdata[DW-1:0];
    assign sel_ctrl = (paddr == ADDR_W'(periodic_wakeup_pkg::STATUS_CONTROL_OFFSET));
    assign sel_count = (paddr == ADDR_W'(periodic_wakeup_pkg::COUNT_VALUE_OFFSET));
    assign sel_mod = (paddr == ADDR_W'(periodic_wakeup_pkg::MODULO_VALUE_OFFSET));
    assign mapped = sel_ctrl | sel_count | sel_mod;

    assign ctrl_view = {periodic_match_flag_reg, source_select_reg, periodic_irq_enable_reg, prescale_select_reg};

    // Clearing the prescaler and counter on control changes
    always_comb
    begin
        counter_clear = 1'b0;
        if (wr_lane && sel_ctrl)
        begin
            if (wbyte[periodic_wakeup_pkg::SRC_HI:periodic_wakeup_pkg::SRC_LO] != source_select_reg)
            begin
                counter_clear = 1'b1; // R03
            end
            if (wbyte[periodic_wakeup_pkg::PS_HI:periodic_wakeup_pkg::PS_LO] != prescale_select_reg)
            begin
                counter_clear = 1'b1; // R05
            end
        end
        if (wr_lane && sel_mod)
        begin
            counter_clear = 1'b1; // R11
        end
    end

    assign match = prescale_tick & (periodic_count_value_reg == periodic_modulo_value_reg); // R09 R10

    // Register updates
    always_comb
    begin
        source_select_next = source_select_reg;
        prescale_select_next = prescale_select_reg;
        periodic_irq_enable_next = periodic_irq_enable_reg;
        periodic_modulo_value_next = periodic_modulo_value_reg;
        if (wr_lane && sel_ctrl)
        begin
            source_select_next = wbyte[periodic_wakeup_pkg::SRC_HI:periodic_wakeup_pkg::SRC_LO];
            prescale_select_next = wbyte[periodic_wakeup_pkg::PS_HI:periodic_wakeup_pkg::PS_LO];
            periodic_irq_enable_next = wbyte[periodic_wakeup_pkg::IE_BIT];
        end
        if (wr_lane && sel_mod)
        begin
            periodic_modulo_value_next = wbyte;
        end
    end

    // Match flag: a match wins over a clear written in the same cycle unless counter_clear is high in that cycle
    always_comb
    begin
        periodic_match_flag_next = periodic_match_flag_reg;
        if (wr_lane && sel_ctrl && wbyte[periodic_wakeup_pkg::FLAG_BIT])
        begin
            periodic_match_flag_next = 1'b0; // R01
        end
        if (match && !counter_clear)
        begin
            periodic_match_flag_next = 1'b1; // R01 R09
        end
    end

    // Main 8-bit up-counter
    always_comb
    begin
        periodic_count_value_next = periodic_count_value_reg;
        if (counter_clear)
        begin
            periodic_count_value_next = periodic_wakeup_pkg::COUNT_RESET; // R03 R05 R11
        end
        else if (match)
        begin
            periodic_count_value_next = periodic_wakeup_pkg::COUNT_RESET; // R09 R10
        end
        else if (prescale_tick)
        begin
            periodic_count_value_next = periodic_count_value_reg + DW'(1); // R14
        end
    end

    // Interrupt request follows flag and enable
    always_comb
    begin
        irq_next = periodic_match_flag_next & periodic_irq_enable_next; // R04
    end

    // Bus answer: one wait state, read data captured while pready is low
    always_comb
    begin
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (access && !pready_reg)
        begin
            pready_next = 1'b1;
            pslverr_next = ~mapped;
            prdata_next = 32'h0000_0000;
            if (!pwrite)
            begin
                if (sel_ctrl)
                begin
                    prdata_next[DW-1:0] = ctrl_view;
                end
                else if (sel_count)
                begin
                    prdata_next[DW-1:0] = periodic_count_value_reg; // R08 R15
                end
                else if (sel_mod)
                begin
                    prdata_next[DW-1:0] = periodic_modulo_value_reg;
                end
            end
        end
    end

    // Control registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            periodic_irq_enable_reg <= 1'b0; // R04
            source_select_reg <= periodic_wakeup_pkg::SRC_RESET; // R03 R13
            prescale_select_reg <= periodic_wakeup_pkg::PS_RESET; // R05 R12
            periodic_modulo_value_reg <= periodic_wakeup_pkg::MODULO_RESET; // R11
        end
        else if (ce)
        begin
            periodic_irq_enable_reg <= periodic_irq_enable_next;
            source_select_reg <= source_select_next;
            prescale_select_reg <= prescale_select_next;
            periodic_modulo_value_reg <= periodic_modulo_value_next;
        end
    end

    // Match flag register
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            periodic_match_flag_reg <= 1'b0; // R01
        end
        else if (ce)
        begin
            periodic_match_flag_reg <= periodic_match_flag_next;
        end
    end

    // Counter register
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            periodic_count_value_reg <= periodic_wakeup_pkg::COUNT_RESET; // R08
        end
        else if (ce)
        begin
            periodic_count_value_reg <= periodic_count_value_next;
        end
    end

    // Interrupt request register
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            irq_reg <= 1'b0;
        end
        else if (ce)
        begin
            irq_reg <= irq_next;
        end
    end

    // Bus answer registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign periodic_irq = irq_reg;
endmodule

/* File: verification/periodic_wakeup_checker_assertions.sv */
// Port assertions for the periodic wakeup counter
`timescale 1ns/10ps
module periodic_wakeup_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic low_power_osc_clock,
    input wire logic external_reference_clock,
    input wire logic internal_reference_clock,
    input wire logic periodic_irq
);
    logic ctrl_wr;
    assign ctrl_wr = pready && pwrite && paddr == 8'h00;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_unmapped_a: assert property (pready |-> pslverr == !(paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08))
        else $error("error flag wrong for address");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    irq_reads_a: assert property (pready && !pwrite && paddr == 8'h00 |-> $past(periodic_irq) == (prdata[7] && prdata[4]))
        else $error("irq disagrees with flag and enable");
    irq_reset_a: assert property ($rose(rstn) |-> !periodic_irq && !pready)
        else $error("output high after reset");
    irq_disable_a: assert property (ctrl_wr && pstrb[0] && !pwdata[4] |=> !periodic_irq)
        else $error("irq stays with enable cleared");
    irq_clear_a: assert property ($fell(periodic_irq) |-> $past(ctrl_wr))
        else $error("irq fell without control write");
    cover property (pready && pslverr);
    cover property ($rose(periodic_irq));
    cover property (ctrl_wr && pwdata[7]);
endmodule

bind periodic_wakeup_counter periodic_wakeup_checker #(.ADDR_W(ADDR_W)) chk_i (.clk, .rstn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .low_power_osc_clock,
    .external_reference_clock, .internal_reference_clock, .periodic_irq);

/* File: verification/periodic_wakeup_counter_test.sv */
// Register-level testbench for the periodic wakeup counter
`timescale 1ns/10ps
module periodic_wakeup_counter_test;
    localparam logic [7:0] CTL = periodic_wakeup_pkg::STATUS_CONTROL_OFFSET;
    localparam logic [7:0] CNT = periodic_wakeup_pkg::COUNT_VALUE_OFFSET;
    localparam logic [7:0] MD = periodic_wakeup_pkg::MODULO_VALUE_OFFSET;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] src = 3'h0;
    logic periodic_irq;
    logic [31:0] q;
    logic e;
    int failures = 0;
    int checks_done = 0;

    periodic_wakeup_counter DUT (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_power_osc_clock(src[0]), .external_reference_clock(src[1]),
        .internal_reference_clock(src[2]), .periodic_irq(periodic_irq));

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x)
        begin
            $display("wrong value %s expected %h seen %h", n, x, g);
            failures++;
        end
    endtask

    // One transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        chk("access cycles", 32'h0000_0002, n);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, x, q);
    endtask

    // Rising edges on one source pin, then time for them to reach the counter
    task automatic pulse(input int s, input int k);
        repeat (k)
        begin
            src[s] <= 1'b1;
            repeat (2) @(posedge clk);
            src[s] <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(CTL, 32'h0000_0000, "ctrl reset");
        rd(CNT, 32'h0000_0000, "count reset");
        rd(MD, 32'h0000_0000, "modulo reset");
        pulse(0, 3);
        rd(CNT, 32'h0000_0000, "stopped");
        apb(1'b0, 8'h0c, 32'h0000_0000);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("test reset done");
        wr(MD, 8'h02);
        wr(CTL, 8'h08);
        pulse(0, 2);
        rd(CNT, 32'h0000_0002, "count up");
        wr(CNT, 8'h55);
        rd(CNT, 32'h0000_0002, "count ro");
        rd(CTL, 32'h0000_0008, "no flag");
        pulse(0, 1);
        rd(CNT, 32'h0000_0000, "wrap");
        rd(CTL, 32'h0000_0088, "flag");
        chk("irq masked", 32'h0, {31'h0, periodic_irq});
        wr(CTL, 8'h18);
        chk("irq on", 32'h1, {31'h0, periodic_irq});
        rd(CTL, 32'h0000_0098, "w1c zero");
        wr(CTL, 8'h98);
        chk("irq off", 32'h0, {31'h0, periodic_irq});
        rd(CTL, 32'h0000_0018, "w1c one");
        pulse(0, 1);
        wr(MD, 8'h02);
        rd(CNT, 32'h0000_0000, "mod clear");
        $display("test match done");
        wr(MD, 8'h00);
        pulse(0, 1);
        rd(CTL, 32'h0000_0098, "mod zero");
        wr(CTL, 8'h88);
        pulse(0, 1);
        rd(CTL, 32'h0000_0088, "mod zero again");
        $display("test modulo zero done");
        wr(MD, 8'hff);
        wr(CTL, 8'hc8);
        pulse(0, 2);
        pulse(1, 2);
        rd(CNT, 32'h0000_0000, "lpo ignored");
        pulse(2, 2);
        rd(CNT, 32'h0000_0002, "int");
        wr(CTL, 8'h08);
        rd(CNT, 32'h0000_0000, "src clear");
        pulse(0, 1);
        pulse(2, 1);
        rd(CNT, 32'h0000_0001, "int ignored");
        wr(CTL, 8'h08);
        rd(CNT, 32'h0000_0001, "same src");
        wr(CTL, 8'he8);
        rd(CNT, 32'h0000_0000, "src clear 2");
        wr(CTL, 8'h08);
        pulse(0, 1);
        $display("test source done");
        wr(CTL, 8'h09);
        rd(CNT, 32'h0000_0000, "ps clear");
        pulse(0, 4);
        rd(CNT, 32'h0000_0002, "div 2");
        ce <= 1'b0;
        pulse(0, 4);
        ce <= 1'b1;
        rd(CNT, 32'h0000_0002, "frozen");
        wr(CTL, 8'h0b);
        pulse(0, 19);
        rd(CNT, 32'h0000_0001, "div 10");
        wr(CTL, 8'h01);
        pulse(0, 16);
        rd(CNT, 32'h0000_0002, "div 8");
        wr(CTL, 8'h28);
        pulse(1, 999);
        rd(CNT, 32'h0000_0000, "div 1000 early");
        pulse(1, 1);
        rd(CNT, 32'h0000_0001, "div 1000");
        wr(CTL, 8'h20);
        pulse(1, 3);
        rd(CNT, 32'h0000_0000, "off");
        $display("test prescale done");
        stop_test();
    end
endmodule
